//--- include/test_status_pkg.sv
package test_status_pkg;

  // ----------------------------------------------------------------
  // status code layout
  // ----------------------------------------------------------------
  localparam int unsigned CARD_FLAG_POS = 4;
  localparam int unsigned TEST_POS      = 2;
  localparam int unsigned PANEL_POS     = 0;

  // test state encodings
  localparam logic [1:0] TEST_UNINIT   = 2'h0;
  localparam logic [1:0] TEST_RUNNING  = 2'h1;
  localparam logic [1:0] TEST_CFG_ERR  = 2'h2;
  localparam logic [1:0] TEST_FINISHED = 2'h3;

  // panel codes: setup switch is the upper bit, run/stop the lower
  localparam logic [1:0] PANEL_NORMAL   = 2'h0;
  localparam logic [1:0] PANEL_STOPPED  = 2'h1;
  localparam logic [1:0] PANEL_MODBUS   = 2'h2;
  localparam logic [1:0] PANEL_TERMINAL = 2'h3;

  // named global codes
  localparam logic [4:0] CARD_OK_UNINIT_TERMINAL_SETUP  = 5'h03;
  localparam logic [4:0] CARD_OK_RUNNING_NORMAL         = 5'h04;
  localparam logic [4:0] CARD_OK_RUNNING_TERMINAL_SETUP = 5'h07;
  localparam logic [4:0] CARD_FAIL_FIRST                = 5'h10;

  // terminal line settings
  localparam int unsigned TERM_BAUD      = 19200;
  localparam int unsigned TERM_DATA_BITS = 8;
  localparam int unsigned TERM_STOP_BITS = 1;

  // log row period
  localparam int unsigned LOG_PERIOD_S = 60;
  localparam int unsigned CLK_HZ       = 125000000;
  localparam longint unsigned LOG_PERIOD_CYC = longint'(LOG_PERIOD_S) * longint'(CLK_HZ);

endpackage

//--- rtl/test_status_state_machine.sv
module test_status_state_machine #(
  parameter longint unsigned LOG_PERIOD_CYCLES = test_status_pkg::LOG_PERIOD_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       setup_select_switch,
  input  wire logic       run_stop_switch,
  input  wire logic       card_missing_flag,
  input  wire logic       boot_strobe,
  input  wire logic       boot_switch_match,
  input  wire logic       boot_was_launched,
  input  wire logic       boot_data_file_found,
  input  wire logic       launch_req,
  input  wire logic       launch_setup_match,
  input  wire logic       finish_req,
  input  wire logic       file_op_done,
  output logic      [4:0] global_status,
  output logic      [1:0] test_state_code,
  output logic      [1:0] panel_switch_code,
  output logic            terminal_menu_en,
  output logic            modbus_en,
  output logic            launch_rejected,
  output logic            create_file_req,
  output logic            log_event_req,
  output logic            append_row_req
);

  // ----------------------------------------------------------------
  // switch and flag synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_ff, sync2_ff;
  logic [2:0] nxt_sync1, nxt_sync2;

  always_comb begin
    nxt_sync1 = {card_missing_flag, setup_select_switch, run_stop_switch};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ----------------------------------------------------------------
  // launch sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_CREATE, ST_EVENT} seq_t;

  seq_t                seq_ff, nxt_seq;
  logic [1:0]          test_ff, nxt_test;
  logic                rej_ff, nxt_rej;
  logic                create_ff, nxt_create;
  logic                event_ff, nxt_event;
  logic                row_ff, nxt_row;
  longint unsigned     tick_ff, nxt_tick;
  logic                card_bad;

  assign card_bad = sync2_ff[2];

  always_comb begin
    nxt_seq    = seq_ff;
    nxt_test   = test_ff;
    nxt_rej    = 1'b0;
    nxt_create = 1'b0;
    nxt_event  = 1'b0;
    nxt_row    = 1'b0;
    nxt_tick   = tick_ff;
    if (boot_strobe) begin
      nxt_seq = ST_IDLE;
      if (boot_was_launched) begin
        nxt_test = boot_data_file_found ? test_status_pkg::TEST_RUNNING
                                        : test_status_pkg::TEST_UNINIT;
      end else begin
        nxt_test = boot_switch_match ? test_status_pkg::TEST_UNINIT
                                     : test_status_pkg::TEST_CFG_ERR;
      end
    end else begin
      unique case (seq_ff)
        ST_IDLE: begin
          // launch only accepted from the terminal menu
          if (launch_req && terminal_menu_en) begin
            if (launch_setup_match && !card_bad) begin
              nxt_seq    = ST_CREATE;
              nxt_create = 1'b1;
            end else begin
              nxt_rej = 1'b1;
            end
          end else if (finish_req && test_ff == test_status_pkg::TEST_RUNNING) begin
            nxt_test = test_status_pkg::TEST_FINISHED;
          end
        end
        ST_CREATE: begin
          if (file_op_done) begin
            nxt_seq   = ST_EVENT;
            nxt_event = 1'b1;
          end
        end
        ST_EVENT: begin
          if (file_op_done) begin
            nxt_seq  = ST_IDLE;
            nxt_test = test_status_pkg::TEST_RUNNING;
            nxt_tick = 64'h0;
          end
        end
      endcase
      // one averaged row per period while running
      if (test_ff == test_status_pkg::TEST_RUNNING && seq_ff == ST_IDLE) begin
        if (tick_ff >= LOG_PERIOD_CYCLES - 64'h1) begin
          nxt_tick = 64'h0;
          nxt_row  = 1'b1;
        end else begin
          nxt_tick = tick_ff + 64'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq_ff    <= ST_IDLE;
      test_ff   <= test_status_pkg::TEST_UNINIT;
      rej_ff    <= 1'b0;
      create_ff <= 1'b0;
      event_ff  <= 1'b0;
      row_ff    <= 1'b0;
      tick_ff   <= 64'h0;
    end else begin
      seq_ff    <= nxt_seq;
      test_ff   <= nxt_test;
      rej_ff    <= nxt_rej;
      create_ff <= nxt_create;
      event_ff  <= nxt_event;
      row_ff    <= nxt_row;
      tick_ff   <= nxt_tick;
    end
  end

  // ----------------------------------------------------------------
  // global status and port selection
  // ----------------------------------------------------------------
  logic [4:0] gs_ff, nxt_gs;
  logic [1:0] panel_ff, nxt_panel;
  logic [1:0] tout_ff, nxt_tout;
  logic       term_ff, nxt_term;
  logic       mb_ff, nxt_mb;

  always_comb begin
    nxt_panel = sync2_ff[1:0];
    nxt_tout  = test_ff;
    // recomputed every cycle from the synchronised card flag and switches and from test_ff
    nxt_gs    = 5'({4'h0, card_bad} << test_status_pkg::CARD_FLAG_POS)
              | 5'({3'h0, test_ff} << test_status_pkg::TEST_POS)
              | 5'({3'h0, sync2_ff[1:0]} << test_status_pkg::PANEL_POS);
    nxt_mb    = (nxt_gs == test_status_pkg::CARD_OK_RUNNING_NORMAL);
    // terminal stays available in the uninit-terminal and running-terminal codes
    nxt_term  = !nxt_mb && (nxt_gs == test_status_pkg::CARD_OK_UNINIT_TERMINAL_SETUP
              || nxt_gs == test_status_pkg::CARD_OK_RUNNING_TERMINAL_SETUP);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gs_ff    <= 5'h00;
      panel_ff <= test_status_pkg::PANEL_NORMAL;
      tout_ff  <= test_status_pkg::TEST_UNINIT;
      term_ff  <= 1'b0;
      mb_ff    <= 1'b0;
    end else begin
      gs_ff    <= nxt_gs;
      panel_ff <= nxt_panel;
      tout_ff  <= nxt_tout;
      term_ff  <= nxt_term;
      mb_ff    <= nxt_mb;
    end
  end

  assign global_status     = gs_ff;
  assign test_state_code   = tout_ff;
  assign panel_switch_code = panel_ff;
  assign terminal_menu_en  = term_ff;
  assign modbus_en         = mb_ff;
  assign launch_rejected   = rej_ff;
  assign create_file_req   = create_ff;
  assign log_event_req     = event_ff;
  assign append_row_req    = row_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  status_sum_a: assert property (@(posedge clk_sys) disable iff (rst)
    global_status == 5'({$past(card_bad), $past(test_ff), $past(sync2_ff[1:0])}))
    else $error("global status not weighted sum");
  card_range_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(card_bad) |-> global_status >= test_status_pkg::CARD_FAIL_FIRST)
    else $error("card fail code below 16");
  boot_cfg_a: assert property (@(posedge clk_sys) disable iff (rst)
    boot_strobe && !boot_was_launched && !boot_switch_match
    |=> test_ff == test_status_pkg::TEST_CFG_ERR)
    else $error("boot mismatch not config error");
  menu_three_a: assert property (@(posedge clk_sys) disable iff (rst)
    global_status == test_status_pkg::CARD_OK_UNINIT_TERMINAL_SETUP |-> terminal_menu_en)
    else $error("menu off in status 3");
  launch_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    create_file_req |-> $past(launch_setup_match) && !$past(card_bad))
    else $error("launch without valid setup");
  event_order_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(test_ff == test_status_pkg::TEST_RUNNING) && !$past(boot_strobe)
    |-> $past(seq_ff) == ST_EVENT)
    else $error("running before event logged");
  modbus_four_a: assert property (@(posedge clk_sys) disable iff (rst)
    modbus_en == (global_status == test_status_pkg::CARD_OK_RUNNING_NORMAL))
    else $error("modbus not tied to status 4");
  menu_mutex_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(modbus_en && terminal_menu_en))
    else $error("menu active with modbus");
  reboot_lost_a: assert property (@(posedge clk_sys) disable iff (rst)
    boot_strobe && boot_was_launched && !boot_data_file_found
    |=> ##1 test_state_code == test_status_pkg::TEST_UNINIT)
    else $error("lost file not reverted");

endmodule

//--- tb/file_agent_model.sv
module file_agent_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic create_file_req,
  input  wire logic log_event_req,
  output logic      file_op_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  // a slow card: each file request is answered after 1 to 3 cycles
  // done is written once per edge, so no edge ever sees two values for it
  always @(posedge clk_sys) begin
    file_op_done <= !rst && !create_file_req && !log_event_req && wait_cnt == 1;
    if (rst) begin
      wait_cnt <= 0;
    end else if (create_file_req || log_event_req) begin
      wait_cnt <= 1 + $urandom_range(2);
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

//--- tb/test_test_status_state_machine.sv
module test_test_status_state_machine;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, setup_select_switch, run_stop_switch, card_missing_flag;
  logic boot_strobe, boot_switch_match, boot_was_launched, boot_data_file_found;
  logic launch_req, launch_setup_match, finish_req, file_op_done;
  logic [4:0] global_status;
  logic [1:0] test_state_code, panel_switch_code;
  logic terminal_menu_en, modbus_en, launch_rejected;
  logic create_file_req, log_event_req, append_row_req;
  int mismatches, samples_checked, et, i, row_base;
  // pulse counters are written only by the counting process below
  int n_create = 0, n_log = 0, n_rej = 0, n_row = 0;
  logic [4:0] es;
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  test_status_state_machine #(.LOG_PERIOD_CYCLES(16)) test_status_state_machine_i (
    .clk_sys, .rst, .setup_select_switch, .run_stop_switch, .card_missing_flag,
    .boot_strobe, .boot_switch_match, .boot_was_launched, .boot_data_file_found,
    .launch_req, .launch_setup_match, .finish_req, .file_op_done, .global_status,
    .test_state_code, .panel_switch_code, .terminal_menu_en, .modbus_en,
    .launch_rejected, .create_file_req, .log_event_req, .append_row_req);
  file_agent_model file_agent_model_i (.clk_sys, .rst, .create_file_req, .log_event_req,
    .file_op_done);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // pulses are counted at the edge that samples them
  always @(posedge clk_sys) begin
    n_create += int'(create_file_req === 1'b1);
    n_log    += int'(log_event_req === 1'b1);
    n_rej    += int'(launch_rejected === 1'b1);
    n_row    += int'(append_row_req === 1'b1);
  end
  task results;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check(input string name, input logic [4:0] seen, input logic [4:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // model of the global code from the pins and the modelled test state
  task chk_status;
    es = 5'(card_missing_flag * 16 + et * 4 + setup_select_switch * 2 + run_stop_switch);
    check("status", global_status, es);
    check("panel", panel_switch_code, {setup_select_switch, run_stop_switch});
    check("modbus", modbus_en, es == 5'h04);
    check("menu", terminal_menu_en, es == 5'h03 || es == 5'h07);
  endtask
  task boot_do(input logic m, input logic f, input logic l);
    {boot_switch_match, boot_data_file_found, boot_was_launched} = {m, f, l};
    boot_strobe = 1'b1;
    cyc(1);
    boot_strobe = 1'b0;
    cyc(3);
    et = l ? (f ? 1 : 0) : (m ? 0 : 2);
    check("boot", test_state_code, 5'(et));
    chk_status;
  endtask
  initial begin
    {setup_select_switch, run_stop_switch, card_missing_flag, boot_strobe} = 4'h0;
    {boot_switch_match, boot_was_launched, boot_data_file_found} = 3'h0;
    {launch_req, launch_setup_match, finish_req} = 3'h0;
    {mismatches, samples_checked, et, row_base} = '0;
    rst = 1'b1;
    void'($urandom(32'h46A8));
    cyc(5);
    rst = 1'b0;
    cyc(1);
    check("reset", global_status, 5'h00);
    for (i = 0; i < 12; i++) begin
      {setup_select_switch, run_stop_switch, card_missing_flag} = 3'($urandom);
      cyc(4);
      chk_status;
    end
    for (i = 0; i < 8; i++) boot_do(i[0], i[1], i[2]);
    boot_do(1'b1, 1'b0, 1'b0);
    {setup_select_switch, run_stop_switch, card_missing_flag} = 3'h6;
    cyc(4);
    chk_status;
    // host enters values that disagree with the sensor board
    launch_req = 1'b1;
    cyc(1);
    launch_req = 1'b0;
    cyc(3);
    check("reject", 5'(n_rej), 5'h01);
    check("nocreate", 5'(n_create), 5'h00);
    launch_setup_match = 1'b1;
    launch_req = 1'b1;
    cyc(1);
    launch_req = 1'b0;
    for (i = 0; i < 40 && test_state_code !== 2'h1; i++) cyc(1);
    if (i == 40) begin
      mismatches++;
      results;
    end
    check("created", 5'(n_create), 5'h01);
    check("logged", 5'(n_log), 5'h01);
    et = 1;
    cyc(1);
    chk_status;
    {setup_select_switch, run_stop_switch} = 2'h0;
    cyc(4);
    chk_status;
    launch_req = 1'b1;
    cyc(1);
    launch_req = 1'b0;
    cyc(3);
    check("ignored", 5'(n_create), 5'h01);
    row_base = n_row;
    cyc(64);
    check("rows", 5'(n_row - row_base), 5'h04);
    card_missing_flag = 1'b1;
    cyc(4);
    chk_status;
    finish_req = 1'b1;
    cyc(1);
    finish_req = 1'b0;
    cyc(3);
    et = 3;
    chk_status;
    results;
  end
endmodule
